// ### rtl/fifo_pair_pkg.sv
package fifo_pair_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_CHAN = 2;
    localparam int WORD_W = 9;
    localparam int DEPTH_DEFAULT = 256;
    localparam int CMP_W = 16;

    // ==========================================================
    // reset values
    localparam logic [WORD_W-1:0] OFS_DEFAULT = 9'h007;
    localparam logic OFS_SEL_EMPTY = 1'b0;

    // ==========================================================
    // register map
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] REG_STATUS = 12'h000;
    localparam logic [APB_AW-1:0] REG_MASK = 12'h004;
    localparam logic [APB_AW-1:0] REG_LEVEL = 12'h008;
    localparam int EV_PER_CHAN = 2;
    localparam int EV_W = EV_PER_CHAN * NUM_CHAN;
    localparam int EV_OVF = 0;
    localparam int EV_UNF = 1;
    localparam int LEVEL_W = 16;
    localparam logic [EV_W-1:0] STATUS_RESET = 4'h0;
    localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

    // ==========================================================
    // types
    typedef enum logic {
        MODE_LOAD = 1'b0,
        MODE_TWO_WE = 1'b1
    } mode_type;

    typedef struct packed {
        logic wclk;
        logic rclk;
        logic wen1_n;
        logic wen2_ld;
        logic ren1_n;
        logic ren2_n;
        logic rst_n;
        logic oe_n;
        logic [WORD_W-1:0] din;
    } pin_type;

    typedef struct packed {
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } bus_state_type;

endpackage

// ### rtl/fifo_mem.sv
`timescale 1ns/10ps
module fifo_mem
    import fifo_pair_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = DEPTH_DEFAULT,
    parameter int AW = $clog2(DEPTH)
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read side
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] cells [DEPTH];

    // storage write
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
    end

    // registered read port
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= cells[rd_addr];
        end
    end

endmodule

// ### rtl/fifo_pair.sv
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
module fifo_pair
    import fifo_pair_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEFAULT
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // apb slave
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // buffer a write side
    input wire logic write_clock_a,
    input wire logic write_enable_primary_a_n,
    input wire logic write_enable_second_or_load_a,
    input wire logic [WORD_W-1:0] input_word_a,
    // buffer a read side
    input wire logic read_clock_a,
    input wire logic read_enable_one_a_n,
    input wire logic read_enable_two_a_n,
    input wire logic output_drive_enable_a_n,
    input wire logic reset_a_n,
    output logic [WORD_W-1:0] output_word_a,
    output logic output_word_a_oe,
    // buffer a flags
    output logic empty_flag_a_n,
    output logic full_flag_a_n,
    output logic almost_empty_flag_a_n,
    output logic almost_full_flag_a_n,
    // buffer b write side
    input wire logic write_clock_b,
    input wire logic write_enable_primary_b_n,
    input wire logic write_enable_second_or_load_b,
    input wire logic [WORD_W-1:0] input_word_b,
    // buffer b read side
    input wire logic read_clock_b,
    input wire logic read_enable_one_b_n,
    input wire logic read_enable_two_b_n,
    input wire logic output_drive_enable_b_n,
    input wire logic reset_b_n,
    output logic [WORD_W-1:0] output_word_b,
    output logic output_word_b_oe,
    // buffer b flags
    output logic empty_flag_b_n,
    output logic full_flag_b_n,
    output logic almost_empty_flag_b_n,
    output logic almost_full_flag_b_n
);

    localparam int ADDR_W = $clog2(DEPTH);
    localparam int CNT_W = ADDR_W + 1;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    // ==========================================================
    // per-buffer state
    typedef struct packed {
        pin_type sync1;
        pin_type sync2;
        logic wclk_d;
        logic rclk_d;
        mode_type mode;
        logic [ADDR_W-1:0] wr_ptr;
        logic [ADDR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
        logic [WORD_W-1:0] ofs_ae;
        logic [WORD_W-1:0] ofs_af;
        logic ofs_sel;
        logic empty_n;
        logic full_n;
        logic aempty_n;
        logic afull_n;
        logic [WORD_W-1:0] q;
        logic q_from_mem;
        logic drive;
        logic ev_ovf;
        logic ev_unf;
    } chan_state_type;

    localparam chan_state_type CHAN_RESET = '{
        sync1: '0,
        sync2: '0,
        wclk_d: 1'b0,
        rclk_d: 1'b0,
        mode: MODE_LOAD,
        wr_ptr: '0,
        rd_ptr: '0,
        count: '0,
        ofs_ae: OFS_DEFAULT,
        ofs_af: OFS_DEFAULT,
        ofs_sel: OFS_SEL_EMPTY,
        empty_n: 1'b0,
        full_n: 1'b1,
        aempty_n: 1'b0,
        afull_n: 1'b1,
        q: '0,
        q_from_mem: 1'b0,
        drive: 1'b0,
        ev_ovf: 1'b0,
        ev_unf: 1'b0
    };

    localparam bus_state_type BUS_RESET = '{
        status: STATUS_RESET,
        mask: MASK_RESET,
        prdata: '0,
        pready: 1'b0,
        pslverr: 1'b0,
        irq: 1'b0
    };

    pin_type pins [NUM_CHAN];
    chan_state_type st [NUM_CHAN];
    chan_state_type next_st [NUM_CHAN];
    logic [WORD_W-1:0] mem_rdata [NUM_CHAN];
    logic mem_we [NUM_CHAN];
    logic mem_re [NUM_CHAN];
    logic [EV_W-1:0] events;
    bus_state_type bus;
    bus_state_type next_bus;

    // ==========================================================
    // pin gathering
    assign pins[0] = {write_clock_a, read_clock_a, write_enable_primary_a_n,
                      write_enable_second_or_load_a, read_enable_one_a_n,
                      read_enable_two_a_n, reset_a_n, output_drive_enable_a_n,
                      input_word_a};
    assign pins[1] = {write_clock_b, read_clock_b, write_enable_primary_b_n,
                      write_enable_second_or_load_b, read_enable_one_b_n,
                      read_enable_two_b_n, reset_b_n, output_drive_enable_b_n,
                      input_word_b};

    // ==========================================================
    // buffers
    // separate per-buffer instances
    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
        logic wr_edge;
        logic rd_edge;
        logic buf_rst;
        logic load_sel;
        logic wr_req;
        logic ofs_wr;
        logic rd_req;
        logic fifo_rd;
        logic ofs_rd;
        logic do_write;
        logic do_read;
        logic [CNT_W-1:0] free;

        fifo_mem #(
            .WIDTH(WORD_W),
            .DEPTH(DEPTH),
            .AW(ADDR_W)
        ) u_mem (
            .mclk(mclk),
            .rst(rst),
            .wr_en(mem_we[i]),
            .wr_addr(st[i].wr_ptr),
            .wr_data(st[i].sync2.din),
            .rd_en(mem_re[i]),
            .rd_addr(st[i].rd_ptr),
            .rd_data(mem_rdata[i])
        );

        // strobe decode from synchronised pins
        always_comb begin
            wr_edge = st[i].sync2.wclk & ~st[i].wclk_d;
            rd_edge = st[i].sync2.rclk & ~st[i].rclk_d;
            buf_rst = ~st[i].sync2.rst_n;
            load_sel = (st[i].mode == MODE_LOAD) & ~st[i].sync2.wen2_ld;
            wr_req = ~st[i].sync2.wen1_n & st[i].sync2.wen2_ld;
            ofs_wr = ~st[i].sync2.wen1_n & load_sel;
            rd_req = ~st[i].sync2.ren1_n & ~st[i].sync2.ren2_n;
            fifo_rd = rd_req & ~load_sel;
            ofs_rd = rd_req & load_sel;
            do_write = wr_edge & wr_req & st[i].full_n & ~buf_rst;
            do_read = rd_edge & fifo_rd & st[i].empty_n & ~buf_rst;
            mem_we[i] = do_write;
            mem_re[i] = do_read;
        end

        // next state of one buffer
        always_comb begin
            next_st[i] = st[i];
            next_st[i].sync1 = pins[i];
            next_st[i].sync2 = st[i].sync1;
            next_st[i].wclk_d = st[i].sync2.wclk;
            next_st[i].rclk_d = st[i].sync2.rclk;
            next_st[i].drive = ~st[i].sync2.oe_n;
            next_st[i].ev_ovf = 1'b0;
            next_st[i].ev_unf = 1'b0;
            next_st[i].q_from_mem = do_read;
            free = '0;
            if (st[i].q_from_mem) begin
                next_st[i].q = mem_rdata[i];
            end
            if (buf_rst) begin
                next_st[i].wr_ptr = '0;
                next_st[i].rd_ptr = '0;
                next_st[i].count = '0;
                next_st[i].empty_n = 1'b0;
                next_st[i].aempty_n = 1'b0;
                next_st[i].full_n = 1'b1;
                next_st[i].afull_n = 1'b1;
                next_st[i].q = '0;
                next_st[i].q_from_mem = 1'b0;
                next_st[i].ofs_ae = OFS_DEFAULT;
                next_st[i].ofs_af = OFS_DEFAULT;
                next_st[i].ofs_sel = OFS_SEL_EMPTY;
                next_st[i].mode = st[i].sync2.wen2_ld ? MODE_TWO_WE : MODE_LOAD;
            end else begin
                if (do_write) begin
                    next_st[i].wr_ptr = ADDR_W'(st[i].wr_ptr + 1'b1);
                end
                if (do_read) begin
                    next_st[i].rd_ptr = ADDR_W'(st[i].rd_ptr + 1'b1);
                end
                // fill level
                case ({do_write, do_read})
                    2'b10: next_st[i].count = CNT_W'(st[i].count + 1'b1);
                    2'b01: next_st[i].count = CNT_W'(st[i].count - 1'b1);
                    default: next_st[i].count = st[i].count;
                endcase
                if (wr_edge & ofs_wr) begin
                    if (st[i].ofs_sel == OFS_SEL_EMPTY) begin
                        next_st[i].ofs_ae = st[i].sync2.din;
                    end else begin
                        next_st[i].ofs_af = st[i].sync2.din;
                    end
                end
                if (rd_edge & ofs_rd) begin
                    next_st[i].q = (st[i].ofs_sel == OFS_SEL_EMPTY) ? st[i].ofs_ae
                                                                  : st[i].ofs_af;
                end
                if ((wr_edge & ofs_wr) | (rd_edge & ofs_rd)) begin
                    next_st[i].ofs_sel = ~st[i].ofs_sel;
                end
                // refused accesses
                next_st[i].ev_ovf = wr_edge & wr_req & ~st[i].full_n;
                next_st[i].ev_unf = rd_edge & fifo_rd & ~st[i].empty_n;
                if (rd_edge) begin
                    next_st[i].empty_n = (next_st[i].count != '0);
                    next_st[i].aempty_n = ~(CMP_W'(next_st[i].count)
                                            <= CMP_W'(next_st[i].ofs_ae));
                end
                free = CNT_W'(CNT_FULL - next_st[i].count);
                if (wr_edge) begin
                    next_st[i].full_n = (next_st[i].count != CNT_FULL);
                    next_st[i].afull_n = ~(CMP_W'(free) <= CMP_W'(next_st[i].ofs_af));
                end
            end
        end

        // buffer state register
        always_ff @(posedge mclk) begin
            if (rst) begin
                st[i] <= CHAN_RESET;
            end else begin
                st[i] <= next_st[i];
            end
        end

        assign events[i*EV_PER_CHAN+EV_OVF] = st[i].ev_ovf;
        assign events[i*EV_PER_CHAN+EV_UNF] = st[i].ev_unf;
    end

    // ==========================================================
    // register bus and interrupt
    always_comb begin
        logic access;
        logic commit;
        logic [EV_W-1:0] clr;
        access = 1'b0;
        commit = 1'b0;
        clr = '0;
        next_bus = bus;
        access = psel & penable & ~bus.pready;
        commit = psel & penable & bus.pready & pwrite;
        next_bus.pready = access;
        next_bus.pslverr = 1'b0;
        // read data and decode
        if (access) begin
            next_bus.prdata = '0;
            case (paddr)
                REG_STATUS: next_bus.prdata = 32'(bus.status);
                REG_MASK: next_bus.prdata = 32'(bus.mask);
                REG_LEVEL: next_bus.prdata = {LEVEL_W'(st[1].count),
                                              LEVEL_W'(st[0].count)};
                default: next_bus.pslverr = 1'b1;
            endcase
        end
        // writes at completing edge
        if (commit) begin
            case (paddr)
                REG_STATUS: clr = pwdata[EV_W-1:0];
                REG_MASK: next_bus.mask = pwdata[EV_W-1:0];
                default: clr = '0;
            endcase
        end
        // sticky status, a new event beats the clear
        next_bus.status = (bus.status & ~clr) | events;
        next_bus.irq = |(next_bus.status & next_bus.mask);
    end

    // bus state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            bus <= BUS_RESET;
        end else begin
            bus <= next_bus;
        end
    end

    // ==========================================================
    // outputs
    assign prdata = bus.prdata;
    assign pready = bus.pready;
    assign pslverr = bus.pslverr;
    assign irq = bus.irq;
    assign output_word_a = st[0].q;
    assign output_word_a_oe = st[0].drive;
    assign empty_flag_a_n = st[0].empty_n;
    assign full_flag_a_n = st[0].full_n;
    assign almost_empty_flag_a_n = st[0].aempty_n;
    assign almost_full_flag_a_n = st[0].afull_n;
    assign output_word_b = st[1].q;
    assign output_word_b_oe = st[1].drive;
    assign empty_flag_b_n = st[1].empty_n;
    assign full_flag_b_n = st[1].full_n;
    assign almost_empty_flag_b_n = st[1].aempty_n;
    assign almost_full_flag_b_n = st[1].afull_n;

endmodule

// ### test/fifo_pair_monitor.sv
`timescale 1ns/10ps
module fifo_pair_monitor
    import fifo_pair_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // apb handshake
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // buffer a pins and flags
    input wire logic write_clock_a,
    input wire logic read_clock_a,
    input wire logic output_drive_enable_a_n,
    input wire logic output_word_a_oe,
    input wire logic empty_flag_a_n,
    input wire logic full_flag_a_n,
    input wire logic almost_empty_flag_a_n,
    input wire logic almost_full_flag_a_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // decoded register addresses
    logic mapped;
    assign mapped = paddr inside {REG_STATUS, REG_MASK, REG_LEVEL};

    // ==========================================================
    // named steps
    sequence access_open;
        psel && penable && !pready;
    endsequence
    sequence drive_low_held;
        !output_drive_enable_a_n [*5];
    endsequence
    sequence drive_high_held;
        output_drive_enable_a_n [*5];
    endsequence
    sequence wclk_seen;
        $past(write_clock_a) || $past(write_clock_a, 2);
    endsequence
    sequence rclk_seen;
        $past(read_clock_a) || $past(read_clock_a, 2);
    endsequence

    // ==========================================================
    // bus answer
    a_ready_once: assert property (access_open |=> pready ##1 !pready)
        else $error("pready not a single pulse one cycle after access");
    a_err_unmapped: assert property (pready && !mapped |-> pslverr)
        else $error("no slave error on unmapped address");
    a_err_mapped: assert property (pready && mapped |-> !pslverr)
        else $error("slave error on mapped address");

    // ==========================================================
    // output drive and flags
    a_drive_on: assert property (drive_low_held |-> output_word_a_oe)
        else $error("outputs not driven while enable low");
    a_drive_off: assert property (drive_high_held |-> !output_word_a_oe)
        else $error("outputs driven while enable high");
    a_full_afull: assert property (!full_flag_a_n |-> !almost_full_flag_a_n)
        else $error("full without almost full");
    a_empty_aempty: assert property (!empty_flag_a_n |-> !almost_empty_flag_a_n)
        else $error("empty without almost empty");
    a_full_by_wclk: assert property ($fell(full_flag_a_n) |-> wclk_seen)
        else $error("full flag set without write clock edge");
    a_empty_by_rclk: assert property ($rose(empty_flag_a_n) |-> rclk_seen)
        else $error("empty flag left without read clock edge");
endmodule

bind fifo_pair fifo_pair_monitor u_mon (
    .mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .write_clock_a(write_clock_a),
    .read_clock_a(read_clock_a), .output_drive_enable_a_n(output_drive_enable_a_n),
    .output_word_a_oe(output_word_a_oe), .empty_flag_a_n(empty_flag_a_n),
    .full_flag_a_n(full_flag_a_n), .almost_empty_flag_a_n(almost_empty_flag_a_n),
    .almost_full_flag_a_n(almost_full_flag_a_n)
);

// ### test/fifo_partner.sv
`timescale 1ns/10ps
module fifo_partner
    import fifo_pair_pkg::*;
(
    // system clock
    input wire logic mclk,
    // pins toward one buffer
    output pin_type pins
);
    // ==========================================================
    // buffer held in reset from power-up
    initial begin
        pins = '{wclk: 0, rclk: 0, wen1_n: 1, wen2_ld: 1, ren1_n: 1, ren2_n: 1,
                 rst_n: 0, oe_n: 0, din: '0};
    end

    // reset pulse, mode pin steady across it
    task automatic do_reset(input logic mode_level);
        @(posedge mclk);
        pins.wen2_ld <= mode_level;
        pins.rst_n <= 0;
        repeat (4) @(posedge mclk);
        pins.rst_n <= 1;
        repeat (6) @(posedge mclk);
        pins.wen2_ld <= 1;
        repeat (4) @(posedge mclk);
    endtask

    // one write clock period; sec low in load mode loads an offset
    task automatic wr(input logic [WORD_W-1:0] d, input logic sec);
        @(posedge mclk);
        pins.din <= d;
        pins.wen1_n <= 0;
        pins.wen2_ld <= sec;
        repeat (4) @(posedge mclk);
        pins.wclk <= 1;
        repeat (4) @(posedge mclk);
        pins.wclk <= 0;
        pins.wen1_n <= 1;
        pins.wen2_ld <= 1;
        pins.din <= ~d; // released data shows the inverse
        repeat (4) @(posedge mclk);
    endtask

    // one read clock period with given enables and load level
    task automatic rd(input logic [1:0] ren_n, input logic ld);
        @(posedge mclk);
        {pins.ren1_n, pins.ren2_n} <= ren_n;
        pins.wen2_ld <= ld;
        repeat (4) @(posedge mclk);
        pins.rclk <= 1;
        repeat (4) @(posedge mclk);
        pins.rclk <= 0;
        {pins.ren1_n, pins.ren2_n} <= 2'b11;
        pins.wen2_ld <= 1;
        repeat (4) @(posedge mclk);
    endtask

    task automatic oe(input logic v);
        @(posedge mclk);
        pins.oe_n <= v;
    endtask
endmodule

// ### test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import fifo_pair_pkg::*;
    localparam int DP = 16;

    // ==========================================================
    // clock, bus and pins
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic [WORD_W-1:0] out_a, out_b, w;
    logic drv_a, drv_b, empty_a, full_a, aea, afa, empty_b, full_b, aeb, afb;
    logic [WORD_W-1:0] q[$];
    pin_type pa, pb;
    int err_total = 0, num_checks = 0, seed;
    always #10 mclk = ~mclk;

    fifo_partner u_pa (.mclk(mclk), .pins(pa));
    fifo_partner u_pb (.mclk(mclk), .pins(pb));
    fifo_pair #(.DEPTH(DP)) DUT (
        .mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .write_clock_a(pa.wclk),
        .write_enable_primary_a_n(pa.wen1_n), .write_enable_second_or_load_a(pa.wen2_ld),
        .input_word_a(pa.din), .read_clock_a(pa.rclk), .read_enable_one_a_n(pa.ren1_n),
        .read_enable_two_a_n(pa.ren2_n), .output_drive_enable_a_n(pa.oe_n),
        .reset_a_n(pa.rst_n), .output_word_a(out_a), .output_word_a_oe(drv_a),
        .empty_flag_a_n(empty_a), .full_flag_a_n(full_a), .almost_empty_flag_a_n(aea),
        .almost_full_flag_a_n(afa), .write_clock_b(pb.wclk),
        .write_enable_primary_b_n(pb.wen1_n), .write_enable_second_or_load_b(pb.wen2_ld),
        .input_word_b(pb.din), .read_clock_b(pb.rclk), .read_enable_one_b_n(pb.ren1_n),
        .read_enable_two_b_n(pb.ren2_n), .output_drive_enable_b_n(pb.oe_n),
        .reset_b_n(pb.rst_n), .output_word_b(out_b), .output_word_b_oe(drv_b),
        .empty_flag_b_n(empty_b), .full_flag_b_n(full_b), .almost_empty_flag_b_n(aeb),
        .almost_full_flag_b_n(afb)
    );

    // ==========================================================
    // helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic stop_test();
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #200us;
        err_total++;
        stop_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        seed = $urandom(4);
        repeat (16) @(posedge mclk);
        rst <= 0;
        fork
            u_pa.do_reset(1'b1);
            u_pb.do_reset(1'b1);
        join
        check("flags_a", {empty_a, full_a, aea, afa}, 4'b0101);
        check("flags_b", {empty_b, full_b, aeb, afb}, 4'b0101);
        u_pa.wr(9'h055, 1'b0);
        apb(0, REG_LEVEL, 0);
        check("level_a", rdat, 0);
        // fill a with random words up to full
        for (int i = 1; i <= DP; i++) begin
            w = 9'($urandom);
            q.push_back(w);
            u_pa.wr(w, 1'b1);
            check("full_a", full_a, i != DP);
            check("afull_a", afa, (DP - i) > int'(OFS_DEFAULT));
        end
        u_pa.wr(9'h1aa, 1'b1);
        apb(0, REG_LEVEL, 0);
        check("level_a", rdat, DP);
        apb(0, REG_STATUS, 0);
        check("status", rdat, 32'h1);
        check("irq", irq, 0);
        apb(1, REG_MASK, 32'hf);
        repeat (2) @(posedge mclk);
        check("irq", irq, 1);
        // drain a, order and read-side flags
        u_pa.rd(2'b01, 1'b1);
        check("word_a", out_a, 0);
        check("empty_a", empty_a, 1);
        for (int i = DP - 1; i >= 0; i--) begin
            u_pa.rd(2'b00, 1'b1);
            w = q.pop_front();
            check("word_a", out_a, w);
            check("aempty_a", aea, i > int'(OFS_DEFAULT));
            check("empty_a", empty_a, i != 0);
        end
        u_pa.rd(2'b00, 1'b1);
        check("word_a", out_a, w);
        apb(0, REG_STATUS, 0);
        check("status", rdat, 32'h3);
        apb(1, REG_STATUS, 32'h1);
        apb(0, REG_STATUS, 0);
        check("status", rdat, 32'h2);
        apb(1, REG_STATUS, 32'h2);
        repeat (2) @(posedge mclk);
        check("irq", irq, 0);
        apb(0, 12'h00c, 0);
        check("unmapped", {err, rdat}, {1'b1, 32'h0});
        // output drive enable
        u_pa.oe(1'b1);
        repeat (6) @(posedge mclk);
        check("oe_a", drv_a, 0);
        check("oe_b", drv_b, 1);
        u_pa.oe(1'b0);
        u_pb.oe(1'b1);
        repeat (6) @(posedge mclk);
        check("oe_a", drv_a, 1);
        check("oe_b", drv_b, 0);
        u_pb.oe(1'b0);
        // buffer reset in mid-run
        u_pa.wr(9'h0f0, 1'b1);
        u_pa.do_reset(1'b1);
        apb(0, REG_LEVEL, 0);
        check("level_a", rdat, 0);
        check("flags_a", {empty_a, full_a, aea, afa}, 4'b0101);
        // b in load mode: offsets read, loaded, read back
        u_pb.do_reset(1'b0);
        u_pb.rd(2'b00, 1'b0);
        check("ofs_ae", out_b, OFS_DEFAULT);
        u_pb.rd(2'b00, 1'b0);
        check("ofs_af", out_b, OFS_DEFAULT);
        u_pb.wr(9'h003, 1'b0);
        u_pb.wr(9'h002, 1'b0);
        u_pb.rd(2'b00, 1'b0);
        check("ofs_ae", out_b, 9'h003);
        u_pb.rd(2'b00, 1'b0);
        check("ofs_af", out_b, 9'h002);
        for (int i = 0; i < 4; i++) begin
            u_pb.wr(9'($urandom), 1'b1);
        end
        u_pb.rd(2'b11, 1'b1);
        check("aempty_b", aeb, 1);
        u_pb.rd(2'b00, 1'b1);
        check("aempty_b", aeb, 0);
        check("flags_b", {empty_b, full_b, aeb, afb}, 4'b1101);
        apb(0, REG_LEVEL, 0);
        check("level_ab", rdat, 32'h0003_0000);
        // fill b up to the programmed almost-full threshold of two
        for (int i = 4; i <= 14; i++) begin
            u_pb.wr(9'($urandom), 1'b1);
            check("afull_b", afb, (DP - i) > 2);
        end
        stop_test();
    end
endmodule
